// ### logic/dac_mode_pkg.sv
// Purpose: Shared constants and types for the mode control and attenuator block
// Assumes: 8-bit registers reached through a 16-bit control word
// Notes: Reserved bits are masked to read as zero
package dac_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Control word layout and register indices
    localparam int WORD_RW_BIT = 15;
    localparam logic [6:0] IDX_LEFT_ATT = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATT = 7'h11;
    localparam logic [6:0] IDX_MUTE_RAMP = 7'h12;
    localparam logic [6:0] IDX_OUT_DEEMPH = 7'h13;
    localparam logic [6:0] IDX_FMT_FILT_CLK = 7'h14;

    // Mute and ramp control fields
    localparam int MUTE_LEFT_BIT = 0;
    localparam int MUTE_RIGHT_BIT = 1;
    localparam int RAMP_RATE_BIT = 2;
    localparam int LOAD_EN_BIT = 3;
    localparam int ZD_MUTE_BIT = 4;
    localparam int OVERSAMPLE_BIT = 6;
    localparam logic [7:0] MUTE_RAMP_MASK = 8'h5f;

    // Output disable and de-emphasis fields
    localparam int LEFT_DIS_BIT = 0;
    localparam int RIGHT_DIS_BIT = 1;
    localparam int DEEMPH_EN_BIT = 4;
    localparam int DEEMPH_RATE_LSB = 5;
    localparam logic [7:0] OUT_DEEMPH_MASK = 8'h73;
    localparam logic [7:0] FMT_MASK = 8'hff;

    // Reset values
    localparam logic [7:0] ATT_RESET = 8'hff;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Attenuator constants
    localparam logic [7:0] ATT_FULL = 8'hff;
    localparam logic [7:0] ATT_MUTE_CODE = 8'h80;
    localparam logic [2:0] STEP_FRAMES_FAST = 3'h2;
    localparam logic [2:0] STEP_FRAMES_SLOW = 3'h4;
    localparam logic [10:0] ZERO_RUN = 11'h400;
    localparam int SAMPLE_W = 24;
    localparam int GAIN_FRAC = 16;
    localparam logic [6:0] GAIN_STEPS = 7'h0c;
    // One 6 dB octave in 0.5 dB steps, taken as an exact halving
    localparam logic [15:0] GAIN_MANT [0:11] = '{16'hffff, 16'hf1ae, 16'he429,
        16'hd766, 16'hcb59, 16'hbff9, 16'hb53b, 16'hab18, 16'ha186, 16'h987d,
        16'h8ff5, 16'h87e7};

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        DEEMPH_44K1 = 2'b00,
        DEEMPH_48K = 2'b01,
        DEEMPH_32K = 2'b10,
        DEEMPH_RSVD = 2'b11
    } deemph_rate_t;

    typedef enum logic {
        OS_64X = 1'b0,
        OS_128X = 1'b1
    } os_rate_t;

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_DOWN = 2'b01,
        RAMP_UP = 2'b10
    } ramp_state_t;

    typedef struct packed {
        logic rw;
        logic [6:0] index;
        logic [7:0] data;
    } ctrl_word_t;

    typedef struct packed {
        ramp_state_t ramp;
        logic [7:0] level;
        logic [10:0] zero_run;
        logic zero_flag;
        logic signed [SAMPLE_W-1:0] out;
    } chan_state_t;

    typedef struct packed {
        logic [2:0] stage;
        logic level;
        logic rise;
    } sync_state_t;

    typedef struct packed {
        logic [7:0] att_left;
        logic [7:0] att_right;
        logic [7:0] mute_ramp;
        logic [7:0] out_deemph;
        logic [7:0] fmt;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [2:0] frame_cnt;
        logic step_tick;
    } bank_state_t;

endpackage

// ### logic/pin_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter and rise pulse
// Assumes: Input is asynchronous to ref_clk
// Notes: Stage 0 feeds stage 1 only
`timescale 1ns/1ns
module pin_sync3 (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise
);
    dac_mode_pkg::sync_state_t q, d;

    ////////////////////////////////////////////////////////////////////////////
    // Level moves only once stages 1 and 2 agree
    always_comb begin
        d = q;
        d.stage = {q.stage[1:0], pin};
        d.rise = 1'b0;
        if (q.stage[1] == q.stage[2]) begin
            d.level = q.stage[2];
            d.rise = q.stage[2] & ~q.level;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign rise = q.rise;
endmodule

// ### logic/atten_channel.sv
// Purpose: One channel of stepped attenuator, soft mute, zero detect and output force
// Assumes: frame_tick once per sample, step_tick from the shared ramp divider
// Notes: Output is refreshed once per frame
`timescale 1ns/1ns
module atten_channel (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic frame_tick,
    input wire logic step_tick,
    input wire logic load_en,
    input wire logic soft_mute,
    input wire logic [7:0] attenuation_code,
    input wire logic zd_mute_en,
    input wire logic output_disable,
    input wire logic signed [dac_mode_pkg::SAMPLE_W-1:0] sample_in,
    output logic [7:0] level,
    output logic zero_flag,
    output logic signed [dac_mode_pkg::SAMPLE_W-1:0] sample_out
);
    dac_mode_pkg::chan_state_t q, d;
    logic [7:0] target, atten;
    logic [6:0] k, octave, frac_idx;
    logic signed [40:0] prod, scaled;
    logic force_zero;

    ////////////////////////////////////////////////////////////////////////////
    // Gain lookup: mantissa per half-dB step, shift per 6 dB
    always_comb begin
        atten = dac_mode_pkg::ATT_FULL - q.level;
        k = atten[6:0];
        octave = k / dac_mode_pkg::GAIN_STEPS;
        frac_idx = k % dac_mode_pkg::GAIN_STEPS;
        prod = $signed(sample_in) * $signed({1'b0, dac_mode_pkg::GAIN_MANT[frac_idx[3:0]]});
        scaled = (prod >>> dac_mode_pkg::GAIN_FRAC) >>> octave;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ramp target: mute drives to the mute code, low codes clamp there
    always_comb begin
        d = q;
        if (soft_mute) begin
            target = dac_mode_pkg::ATT_MUTE_CODE; // RULE8
        end else if (attenuation_code < dac_mode_pkg::ATT_MUTE_CODE) begin
            target = dac_mode_pkg::ATT_MUTE_CODE;
        end else begin
            target = attenuation_code; // RULE9
        end
        // Step from the present level, so a new target never causes a jump
        case (q.ramp)
            dac_mode_pkg::RAMP_IDLE, dac_mode_pkg::RAMP_DOWN, dac_mode_pkg::RAMP_UP: begin
                if (step_tick && q.level > target) begin
                    d.level = q.level - 8'h01; // RULE10 RULE21
                end else if (step_tick && q.level < target) begin
                    d.level = q.level + 8'h01; // RULE10 RULE21
                end
                if (d.level > target) begin
                    d.ramp = dac_mode_pkg::RAMP_DOWN;
                end else if (d.level < target) begin
                    d.ramp = dac_mode_pkg::RAMP_UP;
                end else begin
                    d.ramp = dac_mode_pkg::RAMP_IDLE;
                end
            end
            default: begin
                d.ramp = dac_mode_pkg::RAMP_IDLE;
            end
        endcase
        // Disabled attenuator loses its level and passes full scale
        if (!load_en) begin
            d.level = dac_mode_pkg::ATT_FULL; // RULE5 RULE6
            d.ramp = dac_mode_pkg::RAMP_IDLE;
        end
        // Zero run counter saturates at the detect length
        if (frame_tick) begin
            if (sample_in == '0) begin
                if (q.zero_run != dac_mode_pkg::ZERO_RUN) begin
                    d.zero_run = q.zero_run + 11'h001; // RULE19
                end
            end else begin
                d.zero_run = '0;
            end
            d.zero_flag = (d.zero_run == dac_mode_pkg::ZERO_RUN); // RULE19 RULE11
        end
        // Zero-detect mute uses the flag, the enable never touches the flag
        force_zero = output_disable || (zd_mute_en && d.zero_flag) // RULE14 RULE20 RULE11
            || (q.level <= dac_mode_pkg::ATT_MUTE_CODE); // RULE4
        if (frame_tick) begin
            if (force_zero) begin
                d.out = '0;
            end else if (q.level == dac_mode_pkg::ATT_FULL) begin
                d.out = sample_in;
            end else begin
                d.out = scaled[dac_mode_pkg::SAMPLE_W-1:0]; // RULE3
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '{ramp: dac_mode_pkg::RAMP_IDLE, level: dac_mode_pkg::ATT_FULL,
                   zero_run: 11'h000, zero_flag: 1'b0, out: '0};
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign zero_flag = q.zero_flag;
    assign sample_out = q.out;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_mute_code_silent: assert property ( // RULE4
        frame_tick && q.level <= dac_mode_pkg::ATT_MUTE_CODE |=> q.out == '0)
        else $error("muted level did not silence output");
    chk_disable_midscale: assert property ( // RULE14
        frame_tick && output_disable |=> q.out == '0)
        else $error("disabled channel not at midscale");
    chk_zero_flag_run: assert property ( // RULE19
        $rose(q.zero_flag) |-> $past(q.zero_run) == dac_mode_pkg::ZERO_RUN - 11'h001)
        else $error("zero flag raised before full run");
    chk_unity_pass: assert property ( // RULE3
        frame_tick && q.level == dac_mode_pkg::ATT_FULL && !output_disable
        && sample_in != '0 |=> q.out == $past(sample_in))
        else $error("0 dB level altered the sample");
endmodule

// ### logic/dac_mode_control_attenuator.sv
// Purpose: Mode control registers 0x10..0x14 with stereo attenuator and soft mute
// Assumes: Control words arrive already deserialised as one-cycle strobes
// Notes: Unmapped indices read as zero, reserved bits are masked
// Contract
// RULE1: Word MSB zero writes the indexed register, one reads it.
// RULE2: Each channel keeps its own 8-bit attenuation, reset to all ones.
// RULE3: Codes 129 to 255 give gain of half dB times code minus 255.
// RULE4: Codes 0 to 128 mute the channel completely.
// RULE5: Shared load enable must be one for attenuators to act.
// RULE6: Load enable resets to zero; clearing it drops held attenuation data.
// RULE7: Host should set load enable right after every reset.
// RULE8: Soft mute steps the level down by half dB to full mute.
// RULE9: Releasing soft mute steps the level back up to programmed value.
// RULE10: One step per two frames, or four when ramp rate bit set.
// RULE11: Zero-detect mute enable gates muting only, never the zero flags.
// RULE12: Oversampling bit picks 64x at zero, 128x at one.
// RULE13: Host uses 128x only for sample rates up to 96 kHz.
// RULE14: Output disable forces midscale, otherwise audio passes.
// RULE15: Both output disable bits reset to zero.
// RULE16: De-emphasis enable resets to zero and switches de-emphasis.
// RULE17: Two-bit de-emphasis rate: 44.1, 48, 32 kHz, reserved.
// RULE18: Soft mute bits reset to zero.
// RULE19: 1024 zero frames in a row raise the channel zero flag.
// RULE20: With zero-detect mute on, a zero channel is forced to midscale.
// RULE21: New target during a ramp continues stepping from present level.
// RULE22: Ramp steps count frames taken from the frame clock.
`timescale 1ns/1ns
module dac_mode_control_attenuator (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dac_mode_pkg::ctrl_word_t ctrl_word,
    input wire logic ctrl_valid,
    input wire logic frame_clock,
    input wire logic signed [dac_mode_pkg::SAMPLE_W-1:0] left_data,
    input wire logic signed [dac_mode_pkg::SAMPLE_W-1:0] right_data,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic signed [dac_mode_pkg::SAMPLE_W-1:0] left_output,
    output logic signed [dac_mode_pkg::SAMPLE_W-1:0] right_output,
    output logic zero_flag_left,
    output logic zero_flag_right,
    output logic [7:0] left_level,
    output logic [7:0] right_level,
    output dac_mode_pkg::os_rate_t oversample_rate,
    output logic deemphasis_enable,
    output dac_mode_pkg::deemph_rate_t deemphasis_rate_select,
    output logic [7:0] format_filter_clock
);
    dac_mode_pkg::bank_state_t q, d;
    logic frame_tick;
    logic attenuator_load_enable, soft_mute_left, soft_mute_right;
    logic ramp_rate_select, zero_detect_mute_enable;
    logic left_output_disable, right_output_disable;
    logic [2:0] step_frames;
    logic wr, rd;

    ////////////////////////////////////////////////////////////////////////////
    // Frame clock pin: one tick per sample period
    pin_sync3 frame_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(frame_clock),
        .level(),
        .rise(frame_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Field views of the control registers
    assign attenuator_load_enable = q.mute_ramp[dac_mode_pkg::LOAD_EN_BIT];
    assign soft_mute_left = q.mute_ramp[dac_mode_pkg::MUTE_LEFT_BIT];
    assign soft_mute_right = q.mute_ramp[dac_mode_pkg::MUTE_RIGHT_BIT];
    assign ramp_rate_select = q.mute_ramp[dac_mode_pkg::RAMP_RATE_BIT];
    assign zero_detect_mute_enable = q.mute_ramp[dac_mode_pkg::ZD_MUTE_BIT];
    assign left_output_disable = q.out_deemph[dac_mode_pkg::LEFT_DIS_BIT];
    assign right_output_disable = q.out_deemph[dac_mode_pkg::RIGHT_DIS_BIT];
    assign wr = ctrl_valid && !ctrl_word.rw; // RULE1
    assign rd = ctrl_valid && ctrl_word.rw; // RULE1

    // Mode outputs straight from register flops
    assign oversample_rate = dac_mode_pkg::os_rate_t'(
        q.mute_ramp[dac_mode_pkg::OVERSAMPLE_BIT]); // RULE12
    assign deemphasis_enable = q.out_deemph[dac_mode_pkg::DEEMPH_EN_BIT]; // RULE16
    assign deemphasis_rate_select = dac_mode_pkg::deemph_rate_t'(
        q.out_deemph[dac_mode_pkg::DEEMPH_RATE_LSB +: 2]); // RULE17
    assign format_filter_clock = q.fmt;
    assign read_data = q.rd_data;
    assign read_valid = q.rd_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Register bank, read path and ramp divider
    always_comb begin
        d = q;
        d.rd_valid = 1'b0;
        d.step_tick = 1'b0;
        // Writes; attenuation writes are ignored while the load enable is low
        if (wr) begin
            case (ctrl_word.index)
                dac_mode_pkg::IDX_LEFT_ATT: begin
                    if (attenuator_load_enable) begin
                        d.att_left = ctrl_word.data; // RULE2
                    end
                end
                dac_mode_pkg::IDX_RIGHT_ATT: begin
                    if (attenuator_load_enable) begin
                        d.att_right = ctrl_word.data; // RULE2
                    end
                end
                dac_mode_pkg::IDX_MUTE_RAMP: begin
                    d.mute_ramp = ctrl_word.data & dac_mode_pkg::MUTE_RAMP_MASK;
                end
                dac_mode_pkg::IDX_OUT_DEEMPH: begin
                    d.out_deemph = ctrl_word.data & dac_mode_pkg::OUT_DEEMPH_MASK;
                end
                dac_mode_pkg::IDX_FMT_FILT_CLK: begin
                    d.fmt = ctrl_word.data & dac_mode_pkg::FMT_MASK;
                end
                default: begin
                    d.fmt = q.fmt;
                end
            endcase
        end
        // Clearing the load enable discards both attenuation settings
        if (!d.mute_ramp[dac_mode_pkg::LOAD_EN_BIT]) begin
            d.att_left = dac_mode_pkg::ATT_RESET; // RULE6
            d.att_right = dac_mode_pkg::ATT_RESET; // RULE6
        end
        // Reads answer the next cycle; unmapped indices read as zero
        if (rd) begin
            d.rd_valid = 1'b1;
            case (ctrl_word.index)
                dac_mode_pkg::IDX_LEFT_ATT: d.rd_data = q.att_left;
                dac_mode_pkg::IDX_RIGHT_ATT: d.rd_data = q.att_right;
                dac_mode_pkg::IDX_MUTE_RAMP: d.rd_data = q.mute_ramp;
                dac_mode_pkg::IDX_OUT_DEEMPH: d.rd_data = q.out_deemph;
                dac_mode_pkg::IDX_FMT_FILT_CLK: d.rd_data = q.fmt;
                default: d.rd_data = dac_mode_pkg::READ_UNMAPPED;
            endcase
        end
        // Step pulse every two or four frames
        step_frames = ramp_rate_select ? dac_mode_pkg::STEP_FRAMES_SLOW
                                       : dac_mode_pkg::STEP_FRAMES_FAST; // RULE10
        if (frame_tick) begin
            if (q.frame_cnt + 3'h1 >= step_frames) begin
                d.frame_cnt = 3'h0;
                d.step_tick = 1'b1; // RULE22
            end else begin
                d.frame_cnt = q.frame_cnt + 3'h1; // RULE22
            end
        end
    end

    // Reset leaves mute off, outputs enabled, load enable low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '{att_left: dac_mode_pkg::ATT_RESET, // RULE2
                   att_right: dac_mode_pkg::ATT_RESET,
                   mute_ramp: dac_mode_pkg::CTRL_RESET, // RULE6 RULE18 RULE11
                   out_deemph: dac_mode_pkg::CTRL_RESET, // RULE15 RULE16 RULE17
                   fmt: dac_mode_pkg::CTRL_RESET,
                   rd_data: dac_mode_pkg::READ_UNMAPPED,
                   rd_valid: 1'b0, frame_cnt: 3'h0, step_tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two identical channels
    atten_channel left_chan (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .frame_tick(frame_tick),
        .step_tick(q.step_tick),
        .load_en(attenuator_load_enable),
        .soft_mute(soft_mute_left),
        .attenuation_code(q.att_left),
        .zd_mute_en(zero_detect_mute_enable),
        .output_disable(left_output_disable),
        .sample_in(left_data),
        .level(left_level),
        .zero_flag(zero_flag_left),
        .sample_out(left_output)
    );

    atten_channel right_chan (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .frame_tick(frame_tick),
        .step_tick(q.step_tick),
        .load_en(attenuator_load_enable),
        .soft_mute(soft_mute_right),
        .attenuation_code(q.att_right),
        .zd_mute_en(zero_detect_mute_enable),
        .output_disable(right_output_disable),
        .sample_in(right_data),
        .level(right_level),
        .zero_flag(zero_flag_right),
        .sample_out(right_output)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_read_answer_next: assert property ( // RULE1
        rd |=> read_valid)
        else $error("read not answered next cycle");
    chk_write_no_answer: assert property ( // RULE1
        wr |=> !read_valid)
        else $error("write produced a read answer");
    chk_disabled_full: assert property ( // RULE5
        !attenuator_load_enable |=> left_level == dac_mode_pkg::ATT_FULL
        && right_level == dac_mode_pkg::ATT_FULL)
        else $error("attenuator active while load enable low");
    chk_clear_discards: assert property ( // RULE6
        wr && ctrl_word.index == dac_mode_pkg::IDX_MUTE_RAMP
        && !ctrl_word.data[dac_mode_pkg::LOAD_EN_BIT]
        |=> q.att_left == dac_mode_pkg::ATT_RESET && q.att_right == dac_mode_pkg::ATT_RESET)
        else $error("attenuation data kept after load enable cleared");
    chk_single_step: assert property ( // RULE8
        attenuator_load_enable && $past(attenuator_load_enable) && $changed(left_level)
        |-> left_level == $past(left_level) + 8'h01 || left_level == $past(left_level) - 8'h01)
        else $error("level moved by more than one step");
    chk_step_on_tick: assert property ( // RULE10
        $past(attenuator_load_enable) && $changed(left_level) |-> $past(q.step_tick))
        else $error("level moved without a step tick");
    chk_fast_interval: assert property ( // RULE10
        frame_tick && !ramp_rate_select && q.frame_cnt == 3'h1 |=> q.step_tick)
        else $error("fast ramp did not step after two frames");
    chk_mute_holds_down: assert property ( // RULE8
        soft_mute_left && attenuator_load_enable && $past(soft_mute_left)
        && $past(attenuator_load_enable) |-> left_level <= $past(left_level))
        else $error("level rose while soft mute on");

    cov_mute_reached: cover property (
        soft_mute_left && left_level == dac_mode_pkg::ATT_MUTE_CODE);
    cov_unmute_ramp: cover property (
        !soft_mute_right && $past(right_level) < right_level);
    cov_zero_flag: cover property ($rose(zero_flag_left));
    cov_read_back: cover property (
        rd && ctrl_word.index == dac_mode_pkg::IDX_MUTE_RAMP ##1 read_valid);
endmodule

// ### tb/ctrl_host.sv
// Purpose: Host side model that issues control words to the register bank
// Assumes: Words launch just after a rising edge and are taken at the next one
// Notes: Strobe drops between calls so no two words merge into one
`timescale 1ns/1ns
module ctrl_host (
    input wire logic ref_clk,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    output dac_mode_pkg::ctrl_word_t ctrl_word,
    output logic ctrl_valid
);
    // Idle bus from time zero
    initial begin
        ctrl_word = '0;
        ctrl_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One word per call; the read answer is sampled while it stands
    task automatic xfer(input logic rw, input logic [6:0] idx, input logic [7:0] d,
            output logic [8:0] q);
        @(posedge ref_clk);
        ctrl_word <= '{rw: rw, index: idx, data: d};
        ctrl_valid <= 1'b1;
        @(posedge ref_clk);
        ctrl_valid <= 1'b0;
        #1;
        q = {read_valid, read_data};
    endtask
endmodule

// ### tb/dac_mode_control_attenuator_tb.sv
// Purpose: Self-checking bench for mode registers, ramps and output forcing
// Assumes: Frame clock runs at 16 ref_clk cycles, well above the minimum
// Notes: Right channel goes silent near the end so its zero flag can be seen rising
`timescale 1ns/1ns
module dac_mode_control_attenuator_tb;
    localparam int FP = 16;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic frame_clock = 1'b0;
    logic signed [dac_mode_pkg::SAMPLE_W-1:0] left_data = 24'h123456;
    logic signed [dac_mode_pkg::SAMPLE_W-1:0] right_data = 24'h0abcde;
    logic signed [dac_mode_pkg::SAMPLE_W-1:0] left_output, right_output;
    dac_mode_pkg::ctrl_word_t ctrl_word;
    dac_mode_pkg::os_rate_t oversample_rate;
    dac_mode_pkg::deemph_rate_t deemphasis_rate_select;
    logic ctrl_valid, read_valid, zero_flag_left, zero_flag_right, deemphasis_enable;
    logic [7:0] read_data, left_level, right_level, format_filter_clock;
    logic [8:0] q;
    int num_errors = 0;
    int checks = 0;
    int n;

    // Clocks; frame clock edges land on ref_clk falling edges
    always #2 ref_clk = ~ref_clk;
    always #(FP * 2) frame_clock = ~frame_clock;

    dac_mode_control_attenuator uut (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl_word(ctrl_word),
        .ctrl_valid(ctrl_valid), .frame_clock(frame_clock), .left_data(left_data),
        .right_data(right_data), .read_data(read_data), .read_valid(read_valid),
        .left_output(left_output), .right_output(right_output),
        .zero_flag_left(zero_flag_left), .zero_flag_right(zero_flag_right),
        .left_level(left_level), .right_level(right_level), .oversample_rate(oversample_rate),
        .deemphasis_enable(deemphasis_enable), .deemphasis_rate_select(deemphasis_rate_select),
        .format_filter_clock(format_filter_clock));
    ctrl_host host (.ref_clk(ref_clk), .read_data(read_data), .read_valid(read_valid),
        .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        host.xfer(1'b0, i, d, q);
    endtask
    task automatic rd(input logic [6:0] i, input logic [7:0] e);
        host.xfer(1'b1, i, 8'h00, q);
        chk(q, {1'b1, e});
    endtask
    task automatic waitc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // Cycles until the left level moves; bounded so a stuck ramp cannot hang
    task automatic gap(output int c);
        logic [7:0] l;
        l = left_level;
        c = 0;
        while (left_level === l && c < 400) begin
            @(posedge ref_clk);
            #1;
            c++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(7'h10, 8'hff);
        rd(7'h11, 8'hff);
        rd(7'h12, 8'h00);
        rd(7'h13, 8'h00);
        rd(7'h15, 8'h00);
        chk(oversample_rate, dac_mode_pkg::OS_64X);
        wr(7'h10, 8'h40);
        rd(7'h10, 8'hff);
        wr(7'h12, 8'h08);
        rd(7'h12, 8'h08);
        waitc(4 * FP);
        chk(left_output, left_data);
        chk(right_output, right_data);
        wr(7'h10, 8'hfd);
        gap(n);
        gap(n);
        chk(n, 2 * FP);
        waitc(4 * FP);
        chk(left_level, 8'hfd);
        // Minus 1 dB on the left sample, as the half-dB mantissa gives it
        chk(left_output, 24'h103986);
        // Full soft mute ramp down and back, 125 steps each way
        wr(7'h12, 8'h09);
        waitc(260 * FP);
        chk(left_level, 8'h80);
        chk(left_output, 24'h000000);
        chk(right_level, 8'hff);
        chk(right_output, right_data);
        wr(7'h12, 8'h08);
        waitc(260 * FP);
        chk(left_level, 8'hfd);
        chk(zero_flag_right, 1'b0);
        // Slow rate, then a new target in mid-ramp must not jump
        wr(7'h12, 8'h0c);
        wr(7'h10, 8'hf0);
        gap(n);
        gap(n);
        chk(n, 4 * FP);
        wr(7'h10, 8'hfd);
        gap(n);
        chk(left_level, 8'hfc);
        wr(7'h13, 8'h01);
        waitc(4 * FP);
        chk(left_output, 24'h000000);
        for (int r = 0; r < 4; r++) begin
            wr(7'h13, {1'b1, r[1:0], 5'h10});
            chk(deemphasis_rate_select, r[1:0]);
            chk(deemphasis_enable, 1'b1);
        end
        rd(7'h13, 8'h70);
        wr(7'h14, 8'ha5);
        chk(format_filter_clock, 8'ha5);
        wr(7'h12, 8'h48);
        chk(oversample_rate, dac_mode_pkg::OS_128X);
        wr(7'h12, 8'h00);
        rd(7'h10, 8'hff);
        chk(left_level, 8'hff);
        // Silence the right channel long enough for its zero run to complete
        @(posedge ref_clk);
        right_data <= 24'h000000;
        waitc(1100 * FP);
        chk(zero_flag_right, 1'b1);
        chk(zero_flag_left, 1'b0);
        // Zero-detect mute on: flag untouched, only the silent channel is forced
        wr(7'h12, 8'h18);
        chk(zero_flag_right, 1'b1);
        waitc(2 * FP);
        chk(right_output, 24'h000000);
        chk(left_output, left_data);
        close_out();
    end

    // Watchdog sized well past the expected run of about 26500 cycles
    initial begin
        #(4 * 60000);
        num_errors++;
        close_out();
    end
endmodule
